/* core/cpuex_pkg.sv */
// Constants, opcodes and states for the execution datapath.
// Assumes a single 20 MHz core clock and an active-low async reset.
package cpuex_pkg;
   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int DATA_W  = 8;
   localparam int LIT_W   = 11;
   localparam int PC_W    = 13;
   localparam int FADDR_W = 7;
   localparam int FDEPTH  = 128;
   localparam int PCH_W   = 7;
   localparam int PCH_HI  = 4;
   localparam int PCH_LO  = 3;
   localparam int CNT_W   = 4;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
   localparam logic              FLAG_RST = 1'b0;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 50;
   localparam int INSTR_CYCLE_NS = 200;
   localparam int INSTR_CLKS     = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int SINGLE_CYCLES  = 1;
   localparam int JUMP_CYCLES    = 2;
   // -----------------------------------------------------------------
   // Opcodes and states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_UNCOND_JUMP  = 3'h0,
      OP_OR_LIT_ACC   = 3'h1,
      OP_OR_ACC_FILE  = 3'h2,
      OP_INCR_FILE    = 3'h3,
      OP_SHL_FILE     = 3'h4,
      OP_SHR_FILE     = 3'h5
   } cpuex_op_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } cpuex_state_type;

   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;
endpackage

/* core/cpuex_file_mem.sv */
// Data file of the current bank: one write port, registered read.
// Assumes same-clock write and read address from the execution core.
`timescale 1ns/1ps
`default_nettype none
module cpuex_file_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic             core_clk, // Core clock
   input  wire logic             rst_n,    // Async reset, active low
   input  wire logic             we,       // Write strobe
   input  wire logic [AW-1:0]    waddr,    // Write address
   input  wire logic [WIDTH-1:0] wdata,    // Write data
   input  wire logic [AW-1:0]    raddr,    // Read address
   output logic      [WIDTH-1:0] rdata     // Read data, registered
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem_reg[raddr];
      end
   end
endmodule
`default_nettype wire

/* core/cpuex_exec.sv */
// Execution datapath: jump, OR, increment and logical shifts.
// Assumes instruction fields come from same-clock decode logic.
`timescale 1ns/1ps
`default_nettype none
module cpuex_exec #(
   parameter int INSTR_CLKS = cpuex_pkg::INSTR_CLKS
) (
   input  wire logic                          core_clk,  // Core clock
   input  wire logic                          rst_n,     // Async reset
   input  wire logic                          instr_valid, // Issue strobe
   input  wire logic [2:0]                    instr_op,  // Opcode
   input  wire logic [cpuex_pkg::LIT_W-1:0]   instr_lit, // Literal field
   input  wire logic [cpuex_pkg::FADDR_W-1:0] instr_file, // File address
   input  wire logic                          instr_dest, // Destination
   input  wire logic [cpuex_pkg::PCH_W-1:0]   pc_high_latch, // PC latch
   output logic      [cpuex_pkg::DATA_W-1:0]  acc,       // Accumulator
   output logic                               carry,     // Carry flag
   output logic                               zero,      // Zero flag
   output logic      [cpuex_pkg::PC_W-1:0]    pc,        // Program counter
   output logic                               busy,      // Executing
   output logic                               done       // Commit pulse
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   cpuex_pkg::cpuex_state_type           state_reg, state_next;
   cpuex_pkg::cpuex_op_type              op_reg, op_next;
   logic [cpuex_pkg::CNT_W-1:0]          cnt_reg, cnt_next;
   logic [cpuex_pkg::LIT_W-1:0]          lit_reg, lit_next;
   logic [cpuex_pkg::FADDR_W-1:0]        file_reg, file_next;
   logic                                 dest_reg, dest_next;
   logic [1:0]                           pch_reg, pch_next;
   logic [cpuex_pkg::DATA_W-1:0]         acc_reg, acc_next;
   logic                                 carry_reg, carry_next;
   logic                                 zero_reg, zero_next;
   logic [cpuex_pkg::PC_W-1:0]           pc_reg, pc_next;
   logic                                 busy_reg, busy_next;
   logic                                 done_reg, done_next;

   logic [cpuex_pkg::DATA_W-1:0]         file_rdata;
   logic [cpuex_pkg::DATA_W-1:0]         result;
   logic                                 res_carry;
   logic                                 commit;
   logic                                 mem_we;
   logic                                 op_ok;
   logic [cpuex_pkg::CNT_W-1:0]          last_cnt;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   function automatic logic is_file_op(input cpuex_pkg::cpuex_op_type o);
      return (o != cpuex_pkg::OP_UNCOND_JUMP) &&
             (o != cpuex_pkg::OP_OR_LIT_ACC);
   endfunction

   function automatic logic [3:0] cycles_of(input cpuex_pkg::cpuex_op_type o);
      if (o == cpuex_pkg::OP_UNCOND_JUMP) begin
         return 4'(cpuex_pkg::JUMP_CYCLES * INSTR_CLKS - 1);
      end else begin
         return 4'(cpuex_pkg::SINGLE_CYCLES * INSTR_CLKS - 1);
      end
   endfunction

   // -----------------------------------------------------------------
   // Data file
   // -----------------------------------------------------------------
   cpuex_file_mem #(
      .WIDTH (cpuex_pkg::DATA_W),
      .DEPTH (cpuex_pkg::FDEPTH),
      .AW    (cpuex_pkg::FADDR_W)
   ) u_file (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .we       (mem_we),
      .waddr    (file_reg),
      .wdata    (result),
      .raddr    (file_reg),
      .rdata    (file_rdata)
   );

   // -----------------------------------------------------------------
   // Result path
   // -----------------------------------------------------------------
   always_comb begin
      res_carry = carry_reg;
      case (op_reg)
         cpuex_pkg::OP_OR_LIT_ACC: begin
            result = acc_reg | lit_reg[7:0];
         end
         cpuex_pkg::OP_OR_ACC_FILE: begin
            result = acc_reg | file_rdata;
         end
         cpuex_pkg::OP_INCR_FILE: begin
            result = 8'(file_rdata + 8'h01);
         end
         cpuex_pkg::OP_SHL_FILE: begin
            result    = {file_rdata[6:0], 1'b0};
            res_carry = file_rdata[7];
         end
         cpuex_pkg::OP_SHR_FILE: begin
            result    = {1'b0, file_rdata[7:1]};
            res_carry = file_rdata[0];
         end
         default: begin
            result = 8'h00;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      op_next    = op_reg;
      cnt_next   = cnt_reg;
      lit_next   = lit_reg;
      file_next  = file_reg;
      dest_next  = dest_reg;
      pch_next   = pch_reg;
      acc_next   = acc_reg;
      carry_next = carry_reg;
      zero_next  = zero_reg;
      pc_next    = pc_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      mem_we     = 1'b0;
      op_ok      = (instr_op <= 3'(cpuex_pkg::OP_SHR_FILE));
      last_cnt   = cycles_of(op_reg);
      commit     = (state_reg == cpuex_pkg::ST_RUN) && (cnt_reg == last_cnt);
      case (state_reg)
         cpuex_pkg::ST_IDLE: begin
            if (instr_valid && op_ok) begin
               state_next = cpuex_pkg::ST_RUN;
               op_next    = cpuex_pkg::cpuex_op_type'(instr_op);
               cnt_next   = '0;
               lit_next   = instr_lit;
               file_next  = instr_file;
               dest_next  = instr_dest;
               pch_next   = pc_high_latch[cpuex_pkg::PCH_HI:cpuex_pkg::PCH_LO];
               busy_next  = 1'b1;
            end
         end
         cpuex_pkg::ST_RUN: begin
            cnt_next = 4'(cnt_reg + 4'h1);
            if (commit) begin
               state_next = cpuex_pkg::ST_IDLE;
               busy_next  = 1'b0;
               done_next  = 1'b1;
               if (op_reg == cpuex_pkg::OP_UNCOND_JUMP) begin
                  pc_next = {pch_reg, lit_reg};
               end else begin
                  zero_next  = is_zero(result);
                  carry_next = res_carry;
                  if (!is_file_op(op_reg) ||
                      dest_reg == cpuex_pkg::DEST_ACC) begin
                     acc_next = result;
                  end else begin
                     mem_we = 1'b1;
                  end
               end
            end
         end
         default: begin
            state_next = cpuex_pkg::ST_IDLE;
            busy_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= cpuex_pkg::ST_IDLE;
         op_reg    <= cpuex_pkg::OP_UNCOND_JUMP;
         cnt_reg   <= '0;
         lit_reg   <= '0;
         file_reg  <= '0;
         dest_reg  <= cpuex_pkg::DEST_ACC;
         pch_reg   <= '0;
         acc_reg   <= cpuex_pkg::ACC_RST;
         carry_reg <= cpuex_pkg::FLAG_RST;
         zero_reg  <= cpuex_pkg::FLAG_RST;
         pc_reg    <= cpuex_pkg::PC_RST;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg    <= op_next;
         cnt_reg   <= cnt_next;
         lit_reg   <= lit_next;
         file_reg  <= file_next;
         dest_reg  <= dest_next;
         pch_reg   <= pch_next;
         acc_reg   <= acc_next;
         carry_reg <= carry_next;
         zero_reg  <= zero_next;
         pc_reg    <= pc_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
      end
   end

   assign acc   = acc_reg;
   assign carry = carry_reg;
   assign zero  = zero_reg;
   assign pc    = pc_reg;
   assign busy  = busy_reg;
   assign done  = done_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence take_jump;
      state_reg == cpuex_pkg::ST_IDLE && instr_valid &&
      instr_op == 3'(cpuex_pkg::OP_UNCOND_JUMP);
   endsequence

   sequence take_single;
      state_reg == cpuex_pkg::ST_IDLE && instr_valid && op_ok &&
      instr_op != 3'(cpuex_pkg::OP_UNCOND_JUMP);
   endsequence

   sequence commit_of(cpuex_pkg::cpuex_op_type o);
      done_reg && op_reg == o;
   endsequence

   a_jump_low_bits: assert property (
      commit_of(cpuex_pkg::OP_UNCOND_JUMP) |->
      pc_reg[10:0] == $past(lit_reg))
      else $error("Jump low bits wrong");

   a_jump_high_bits: assert property (
      take_jump |=> ##8 (pc_reg[12:11] == $past(pch_reg, 8)))
      else $error("Jump high bits wrong");

   a_jump_two_cycles: assert property (
      take_jump |=> (busy_reg && !done_reg) [*8] ##1 (done_reg && !busy_reg))
      else $error("Jump length wrong");

   a_or_literal: assert property (
      commit_of(cpuex_pkg::OP_OR_LIT_ACC) |->
      acc_reg == ($past(acc_reg) | $past(lit_reg[7:0])))
      else $error("OR literal result wrong");

   a_incr_carry_kept: assert property (
      commit_of(cpuex_pkg::OP_INCR_FILE) |->
      $stable(carry_reg) && $past(result) == 8'($past(file_rdata) + 8'h01))
      else $error("Increment wrong");

   a_or_file: assert property (
      commit_of(cpuex_pkg::OP_OR_ACC_FILE) |->
      $past(result) == ($past(acc_reg) | $past(file_rdata)))
      else $error("OR file result wrong");

   a_dest_select: assert property (
      done_reg && is_file_op(op_reg) |->
      ($past(mem_we) == dest_reg) &&
      (dest_reg || acc_reg == $past(result)))
      else $error("Destination routing wrong");

   a_shift_left: assert property (
      commit_of(cpuex_pkg::OP_SHL_FILE) |->
      carry_reg == $past(file_rdata[7]) &&
      $past(result) == {$past(file_rdata[6:0]), 1'b0})
      else $error("Left shift wrong");

   a_shift_right: assert property (
      commit_of(cpuex_pkg::OP_SHR_FILE) |->
      carry_reg == $past(file_rdata[0]) &&
      $past(result) == {1'b0, $past(file_rdata[7:1])})
      else $error("Right shift wrong");

   a_zero_flag: assert property (
      done_reg && op_reg != cpuex_pkg::OP_UNCOND_JUMP |->
      zero_reg == ($past(result) == 8'h00))
      else $error("Zero flag wrong");

   a_single_cycle: assert property (
      take_single |=> (busy_reg && !done_reg) [*4] ##1 (done_reg && !busy_reg))
      else $error("Single cycle length wrong");
endmodule
`default_nettype wire

/* dv/cpuex_seq_model.sv */
// Fetch/decode stand-in: presents one instruction per bench request.
// Assumes the same core clock as the datapath and one request at a time.
`timescale 1ns/1ps
`default_nettype none
module cpuex_seq_model (
   input  wire logic        core_clk,            // Core clock
   input  wire logic        rst_n,               // Async reset, active low
   input  wire logic        go,                  // Bench request
   input  wire logic [2:0]  go_op,               // Requested opcode
   input  wire logic [10:0] go_lit,              // Requested literal
   input  wire logic [6:0]  go_file,             // Requested file address
   input  wire logic        go_dest,             // Requested destination
   input  wire logic [6:0]  go_pch,              // Requested latch value
   input  wire logic        busy,                // Datapath busy
   output logic             instr_valid = 1'b0,  // Issue strobe
   output logic      [2:0]  instr_op = 3'h0,     // Opcode
   output logic      [10:0] instr_lit = 11'h000, // Literal
   output logic      [6:0]  instr_file = 7'h00,  // File address
   output logic             instr_dest = 1'b0,   // Destination
   output logic      [6:0]  pc_high_latch = 7'h00 // Latch value
);
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_valid <= 1'b0;
      end else if (instr_valid && !busy) begin
         // Taken: fields stop holding the old value
         instr_valid   <= 1'b0;
         instr_op      <= ~instr_op;
         instr_lit     <= ~instr_lit;
         instr_file    <= ~instr_file;
         instr_dest    <= ~instr_dest;
         pc_high_latch <= ~pc_high_latch;
      end else if (go) begin
         instr_valid   <= 1'b1;
         instr_op      <= go_op;
         instr_lit     <= go_lit;
         instr_file    <= go_file;
         instr_dest    <= go_dest;
         pc_high_latch <= go_pch;
      end
   end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench: integer model against the execution datapath.
// Assumes cpuex_pkg, cpuex_exec and the sequencer model are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        go       = 1'b0;
   logic [2:0]  go_op    = 3'h0;
   logic [10:0] go_lit   = 11'h000;
   logic [6:0]  go_file  = 7'h00;
   logic        go_dest  = 1'b0;
   logic [6:0]  go_pch   = 7'h00;
   logic        instr_valid, instr_dest, carry, zero, busy, done;
   logic [2:0]  instr_op;
   logic [10:0] instr_lit;
   logic [6:0]  instr_file, pc_high_latch;
   logic [7:0]  acc;
   logic [12:0] pc;
   logic [31:0] seed = 32'h1573_a428;
   int          fails = 0, num_checks = 0, n, m_acc, m_c, m_z, m_pc;
   int          mem [128];
   int          addrs [4] = '{0, 127, 42, 85};
   bit          c_known;

   always #25 core_clk = ~core_clk;

   cpuex_seq_model i_seq (.core_clk(core_clk), .rst_n(rst_n), .go(go),
      .go_op(go_op), .go_lit(go_lit), .go_file(go_file), .go_dest(go_dest),
      .go_pch(go_pch), .busy(busy), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_lit(instr_lit), .instr_file(instr_file),
      .instr_dest(instr_dest), .pc_high_latch(pc_high_latch));

   cpuex_exec #(.INSTR_CLKS(cpuex_pkg::INSTR_CLKS)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_lit(instr_lit), .instr_file(instr_file),
      .instr_dest(instr_dest), .pc_high_latch(pc_high_latch), .acc(acc),
      .carry(carry), .zero(zero), .pc(pc), .busy(busy), .done(done));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Reset pulse of three cycles, outputs checked while it is held
   task automatic do_reset();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("acc", 32'(acc), 0);
      check("pc", 32'(pc), 0);
      check("flags", 32'({carry, zero, busy, done}), 0);
      @(posedge core_clk);
      rst_n <= 1'b1;
      m_acc = 0;
      m_c = 0;
      m_z = 0;
      m_pc = 0;
      c_known = 1'b1;
   endtask

   // Issue one instruction; n is the edge count to done, 0 if none
   task automatic run(input logic [2:0] op, input logic [10:0] lit,
                      input logic [6:0] f, input logic d,
                      input logic [6:0] pch);
      @(posedge core_clk);
      go <= 1'b1;
      go_op <= op;
      go_lit <= lit;
      go_file <= f;
      go_dest <= d;
      go_pch <= pch;
      @(posedge core_clk);
      go <= 1'b0;
      n = 1;
      while (n < 14) begin
         @(posedge core_clk);
         #1;
         n++;
         if (done === 1'b1) break;
      end
      if (n == 14) n = 0;
   endtask

   // Model one instruction, run it, compare cycle count, acc, zero, carry if known, pc and busy
   task automatic step(input logic [2:0] op, input logic [10:0] lit,
                       input logic [6:0] f, input logic d,
                       input logic [6:0] pch);
      int src, r, cyc;
      src = mem[f];
      r = -1;
      cyc = 1;
      case (op)
         3'h0: begin m_pc = {pch[4:3], lit}; cyc = 2; end
         3'h1: r = m_acc | lit[7:0];
         3'h2: r = m_acc | src;
         3'h3: r = (src + 1) & 255;
         3'h4: begin r = (src << 1) & 255; m_c = src >> 7; c_known = 1; end
         3'h5: begin r = src >> 1; m_c = src & 1; c_known = 1; end
         default: cyc = 0;
      endcase
      if (r >= 0) begin
         m_z = (r == 0);
         if (op == 3'h1 || !d) m_acc = r; else mem[f] = r;
      end
      run(op, lit, f, d, pch);
      check("cycles", n, cyc ? 2 + cpuex_pkg::INSTR_CLKS * cyc : 0);
      check("acc", 32'(acc), m_acc);
      check("zero", 32'(zero), m_z);
      if (c_known) check("carry", 32'(carry), m_c);
      check("pc", 32'(pc), m_pc);
      check("busy", 32'(busy), 0);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] x;
      do_reset();
      foreach (addrs[i]) begin
         // Eight left shifts clear an unknown file register
         repeat (8) run(3'h4, 11'h000, 7'(addrs[i]), 1'b1, 7'h00);
         mem[addrs[i]] = 0;
         check("zero", 32'(zero), 1);
         check("acc", 32'(acc), 0);
      end
      c_known = 1'b0;
      m_z = 1;
      $display("test reset_and_clear done");
      step(3'h1, 11'h0ff, 7'h00, 1'b0, 7'h00);
      step(3'h2, 11'h000, 7'h7f, 1'b1, 7'h00);
      step(3'h3, 11'h000, 7'h7f, 1'b0, 7'h00);
      step(3'h0, 11'h7ff, 7'h00, 1'b0, 7'h18);
      $display("test wrap_and_jump done");
      repeat (2) begin
         repeat (120) begin
            x = xorshift();
            step(x[2:0], x[13:3], 7'(addrs[x[15:14]]), x[16], x[23:17]);
         end
         do_reset();
      end
      $display("test random_ops done");
      final_report();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("watchdog expired");
      final_report();
   end
endmodule
`default_nettype wire
